// ==== core/sram_tap.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tap_regs.svh"

module sram_tap (
    input wire logic SYS_CLK, // Memory clock, 25 MHz
    input wire logic RST_B, // Synchronous reset, active low
    input wire logic TEST_CLK, // Serial test clock
    input wire logic TEST_MODE, // Mode select, board pulls it high
    input wire logic TEST_DIN, // Serial data in
    output logic TEST_DOUT, // Serial data out
    output logic TEST_DOUT_OE, // High while serial out is driven
    input wire logic [`RING_W-1:0] PIN_IN, // Ring pin levels
    input wire logic [`RING_W-1:0] CORE_OUT, // Memory output data
    input wire logic CORE_OE, // Memory output enable
    output logic [`RING_W-1:0] PIN_OUT, // Output bus data
    output logic [`RING_W-1:0] PIN_OE // Output bus drive enables
);
    import tap_pkg::*;

    // Test clock domain.
    logic rst_sync;
    logic tap_rst;
    logic [`RING_W-1:0] ring_sync;
    tap_state_t state;
    tap_state_t next_state;
    logic [`IR_W-1:0] ir;
    logic [`IR_W-1:0] ir_sh;
    logic [`IR_W-1:0] next_ir;
    logic bypass;
    logic [`ID_W-1:0] id_sh;
    logic [`BSR_LEN-1:0] bsr_sh;
    bsr_t upd;
    logic sel_bsr;
    logic sel_id;
    logic sel_bypass;
    logic dr_lsb;
    logic shifting;

    // Mode word launched on the test clock, then the system clock domain.
    mode_t mode_tx;
    mode_t mode_s;
    logic tog_seen;
    bsr_t pre;

    // The test domain has no reset pin of its own; the power-up reset
    // reaches it through three stages clocked by the test clock.
    sync_stage #(.W(1)) u_rst_sync (
        .clk(TEST_CLK),
        .d(RST_B),
        .q(rst_sync)
    );

    always_ff @(posedge TEST_CLK) begin
        tap_rst <= ~rst_sync;
    end

    // Pin levels move on the memory clock, so they are resynchronised
    // before capture; a capture can still see a value mid-transition.
    sync_stage #(.W(`RING_W)) u_ring_sync (
        .clk(TEST_CLK),
        .d(PIN_IN),
        .q(ring_sync)
    );

    always_comb begin
        next_state = state;
        case (state)
            TEST_RESET: next_state = TEST_MODE ? TEST_RESET : RUN_IDLE;
            RUN_IDLE: next_state = TEST_MODE ? SEL_DR : RUN_IDLE;
            SEL_DR: next_state = TEST_MODE ? SEL_IR : CAP_DR;
            CAP_DR: next_state = TEST_MODE ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: next_state = TEST_MODE ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: next_state = TEST_MODE ? UPD_DR : PAUSE_DR;
            PAUSE_DR: next_state = TEST_MODE ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: next_state = TEST_MODE ? UPD_DR : SHIFT_DR;
            UPD_DR: next_state = TEST_MODE ? SEL_DR : RUN_IDLE;
            SEL_IR: next_state = TEST_MODE ? TEST_RESET : CAP_IR;
            CAP_IR: next_state = TEST_MODE ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: next_state = TEST_MODE ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: next_state = TEST_MODE ? UPD_IR : PAUSE_IR;
            PAUSE_IR: next_state = TEST_MODE ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: next_state = TEST_MODE ? UPD_IR : SHIFT_IR;
            UPD_IR: next_state = TEST_MODE ? SEL_DR : RUN_IDLE;
            default: next_state = TEST_RESET;
        endcase
    end

    // Five high mode samples reach reset from any state.
    always_ff @(posedge TEST_CLK) begin
        if (tap_rst) begin
            state <= TEST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Instruction decode; any code outside the four decoded ones selects
    // bypass, so a stray code never breaks the chain.
    always_comb begin
        sel_bsr = (ir == `OP_EXTEST) || (ir == `OP_SAMPLE) ||
                  (ir == `OP_SAMPLE_Z);
        sel_id = (ir == `OP_IDCODE);
        sel_bypass = !sel_bsr && !sel_id;
    end

    always_ff @(posedge TEST_CLK) begin
        if (tap_rst || state == TEST_RESET) begin
            ir_sh <= `IR_CAPTURE;
        end else if (state == CAP_IR) begin
            ir_sh <= `IR_CAPTURE;
        end else if (state == SHIFT_IR) begin
            ir_sh <= {TEST_DIN, ir_sh[`IR_W-1:1]};
        end
    end

    always_ff @(posedge TEST_CLK) begin
        if (tap_rst || state == TEST_RESET) begin
            ir <= `OP_IDCODE;
        end else if (state == UPD_IR) begin
            ir <= ir_sh;
        end
    end

    always_ff @(posedge TEST_CLK) begin
        if (tap_rst) begin
            bypass <= 1'b0;
        end else if (sel_bypass && state == CAP_DR) begin
            bypass <= 1'b0;
        end else if (sel_bypass && state == SHIFT_DR) begin
            bypass <= TEST_DIN;
        end
    end

    always_ff @(posedge TEST_CLK) begin
        if (tap_rst) begin
            id_sh <= `ID_VALUE;
        end else if (sel_id && state == CAP_DR) begin
            id_sh <= `ID_VALUE;
        end else if (sel_id && state == SHIFT_DR) begin
            id_sh <= {TEST_DIN, id_sh[`ID_W-1:1]};
        end
    end

    // The gate cell captures its own held value, so it survives a sample.
    always_ff @(posedge TEST_CLK) begin
        if (tap_rst) begin
            bsr_sh <= '0;
        end else if (sel_bsr && state == CAP_DR) begin
            bsr_sh <= {upd.gate, ring_sync};
        end else if (sel_bsr && state == SHIFT_DR) begin
            bsr_sh <= {TEST_DIN, bsr_sh[`BSR_LEN-1:1]};
        end
    end

    // Update latches; the toggle tells the memory side a new word stands.
    always_ff @(posedge TEST_CLK) begin
        if (tap_rst || state == TEST_RESET) begin
            upd.gate <= 1'b1;
        end else if (sel_bsr && state == UPD_DR) begin
            upd.gate <= bsr_sh[`BSR_GATE];
        end
    end

    always_ff @(posedge TEST_CLK) begin
        if (tap_rst) begin
            upd.data <= '0;
        end else if (sel_bsr && state == UPD_DR) begin
            upd.data <= bsr_sh[`RING_W-1:0];
        end
    end

    // Value the instruction takes at this edge, so the memory side hears
    // of a new mode even when the test clock stops right after Update-IR.
    always_comb begin
        if (state == TEST_RESET) begin
            next_ir = `OP_IDCODE;
        end else if (state == UPD_IR) begin
            next_ir = ir_sh;
        end else begin
            next_ir = ir;
        end
    end

    // Exactly one register feeds the serial output at any time.
    always_comb begin
        if (sel_bsr) begin
            dr_lsb = bsr_sh[0];
        end else if (sel_id) begin
            dr_lsb = id_sh[0];
        end else begin
            dr_lsb = bypass;
        end
        shifting = (state == SHIFT_DR) || (state == SHIFT_IR);
    end

    // The output is launched half a period ahead of the far end's sample.
    always_ff @(negedge TEST_CLK) begin
        if (tap_rst) begin
            TEST_DOUT <= 1'b0;
        end else if (state == SHIFT_IR) begin
            TEST_DOUT <= ir_sh[0];
        end else begin
            TEST_DOUT <= dr_lsb;
        end
    end

    always_ff @(negedge TEST_CLK) begin
        if (tap_rst) begin
            TEST_DOUT_OE <= 1'b0;
        end else begin
            TEST_DOUT_OE <= shifting;
        end
    end

    // Mode levels change only at an update or reset, on the same edge as
    // the toggle, so each bit crosses to the memory side alongside it.
    always_ff @(posedge TEST_CLK) begin
        if (tap_rst) begin
            mode_tx <= '0;
        end else begin
            if (state == UPD_DR || state == UPD_IR ||
                state == TEST_RESET) begin
                mode_tx.tog <= ~mode_tx.tog;
            end
            mode_tx.ext <= (next_ir == `OP_EXTEST);
            mode_tx.hiz <= (next_ir == `OP_SAMPLE_Z);
        end
    end

    sync_stage #(.W($bits(mode_t))) u_mode_sync (
        .clk(SYS_CLK),
        .d(mode_tx),
        .q(mode_s)
    );

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            tog_seen <= 1'b0;
        end else begin
            tog_seen <= mode_s.tog;
        end
    end

    // The held word is taken only after its toggle has crossed.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            pre.gate <= 1'b1;
            pre.data <= '0;
        end else if (tog_seen != mode_s.tog) begin
            pre <= upd;
        end
    end

    // Outside the two pin modes the memory drives its bus untouched,
    // whatever the test logic is doing.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            PIN_OUT <= '0;
            PIN_OE <= '0;
        end else if (mode_s.ext) begin
            PIN_OUT <= pre.data;
            PIN_OE <= {`RING_W{pre.gate}};
        end else if (mode_s.hiz) begin
            PIN_OUT <= CORE_OUT;
            PIN_OE <= '0;
        end else begin
            PIN_OUT <= CORE_OUT;
            PIN_OE <= {`RING_W{CORE_OE}};
        end
    end

    sequence mode_high5_s;
        TEST_MODE [*5];
    endsequence

    sequence ir_capture_s;
        state == CAP_IR;
    endsequence

    property five_high_reset_p;
        @(posedge TEST_CLK) disable iff (tap_rst)
        mode_high5_s |=> state == TEST_RESET;
    endproperty

    tlr_after_five_a: assert property (five_high_reset_p)
        else $error("five high mode samples did not reset");

    ir_reset_id_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        state == TEST_RESET |=> ir == `OP_IDCODE)
        else $error("reset did not load identification code");

    property capture_ir_p;
        @(posedge TEST_CLK) disable iff (tap_rst)
        ir_capture_s |=> ir_sh[1:0] == 2'h1;
    endproperty

    cap_ir_pattern_a: assert property (capture_ir_p)
        else $error("capture-IR pattern wrong");

    ir_update_only_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        state != UPD_IR && state != TEST_RESET |=> $stable(ir))
        else $error("instruction changed outside update");

    bypass_clear_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        state == CAP_DR && sel_bypass |=> bypass == 1'b0)
        else $error("bypass not cleared at capture");

    reserved_bypass_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        state == SHIFT_DR && ir == 3'h3 |=> bypass == $past(TEST_DIN))
        else $error("reserved code did not select bypass");

    id_capture_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        state == CAP_DR && ir == `OP_IDCODE |=> id_sh == `ID_VALUE)
        else $error("identification code not captured");

    msb_entry_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        state == SHIFT_DR && sel_bsr
        |=> bsr_sh[`BSR_LEN-1] == $past(TEST_DIN) &&
            bsr_sh[`BSR_LEN-2:0] == $past(bsr_sh[`BSR_LEN-1:1]))
        else $error("boundary shift order wrong");

    dout_enable_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        !tap_rst
        |-> TEST_DOUT_OE == (state == SHIFT_DR || state == SHIFT_IR))
        else $error("serial output enable disagrees with state");

    gate_preset_a: assert property (
        @(posedge TEST_CLK) disable iff (tap_rst)
        state == TEST_RESET |=> upd.gate)
        else $error("gate cell not preset high");

    hiz_float_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        mode_s.hiz && !mode_s.ext |=> PIN_OE == '0)
        else $error("output bus not floated in high-Z sample");

    normal_pass_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        !mode_s.ext && !mode_s.hiz
        |=> PIN_OUT == $past(CORE_OUT) &&
            PIN_OE == {`RING_W{$past(CORE_OE)}})
        else $error("memory path disturbed in normal mode");

    extest_drive_a: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        mode_s.ext |=> PIN_OUT == $past(pre.data))
        else $error("preloaded data not driven in external test");

endmodule // sram_tap

`default_nettype wire

// ==== core/tap_regs.svh ====
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

`define IR_W 3
`define ID_W 32
`define RING_W 8
`define BSR_LEN 9
`define BSR_GATE 8
`define OP_EXTEST 3'h0
`define OP_IDCODE 3'h1
`define OP_SAMPLE_Z 3'h2
`define OP_SAMPLE 3'h4
`define OP_BYPASS 3'h7
`define IR_CAPTURE 3'h1
// Identification value is arbitrary; bit 0 is set as the standard requires.
`define ID_VALUE 32'h0a5c_3001
`define SYNC_STAGES 2

`endif

// ==== core/tap_pkg.sv ====
`include "tap_regs.svh"

package tap_pkg;

    typedef enum logic [3:0] {
        TEST_RESET, RUN_IDLE,
        SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tap_state_t;

    typedef struct packed {
        logic gate;
        logic [`RING_W-1:0] data;
    } bsr_t;

    typedef struct packed {
        logic tog;
        logic hiz;
        logic ext;
    } mode_t;

endpackage

// ==== core/sync_stage.sv ====
`timescale 1ns/100ps
`default_nettype none

module sync_stage #(
    parameter int W = 1
) (
    input wire logic clk, // Destination clock
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        meta <= d;
    end

    always_ff @(posedge clk) begin
        q <= meta;
    end
endmodule // sync_stage

`default_nettype wire

// ==== dv/tap_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module tap_ctrl_model (
    output logic tck, // Test clock, still between frames
    output logic tms, // Mode select
    output logic tdi, // Serial data to the port
    input wire logic tdo, // Serial data from the port
    input wire logic tdo_oe // Serial output enable
);
    // Mode select rests high, as the pulled-up pin would read.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One pulse; the port's output is taken at the rise, where it is settled.
    task automatic tick(input logic m, input logic d, output logic o,
                        output logic e);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        // A released output reads as the inverse, so a lost enable shows.
        o = tdo_oe ? tdo : ~tdo;
        e = tdo_oe;
        #40 tck = 1'b0;
    endtask

    // Data in is toggled on moves so a stale level is never mistaken for data.
    task automatic move(input logic m);
        logic o, e;
        tick(m, ~tdi, o, e);
    endtask

    task automatic reset5();
        repeat (5) move(1'b1);
        move(1'b0);
    endtask

    // Run-Idle, scan n bits of one register, Update, back to Run-Idle.
    task automatic scan(input logic ir, input logic [31:0] din,
                        input int n, output logic [31:0] dout,
                        output logic oe_ok);
        logic o, e;
        dout = '0;
        oe_ok = 1'b1;
        move(1'b1);
        if (ir) move(1'b1);
        move(1'b0);
        move(1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o, e);
            dout[i] = o;
            oe_ok &= e;
        end
        move(1'b1);
        move(1'b0);
    endtask
endmodule // tap_ctrl_model

`default_nettype wire

// ==== dv/sram_boundary_scan_tap_test.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tap_regs.svh"

module sram_boundary_scan_tap_test;
    logic sys_clk, rst_b, tck, tms, tdi, tdo, tdo_oe, core_oe;
    logic [`RING_W-1:0] pin_in, core_out, pin_out, pin_oe;
    logic [31:0] dout;
    logic oe_ok;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    sram_tap dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .TEST_CLK(tck),
        .TEST_MODE(tms), .TEST_DIN(tdi), .TEST_DOUT(tdo),
        .TEST_DOUT_OE(tdo_oe), .PIN_IN(pin_in), .CORE_OUT(core_out),
        .CORE_OE(core_oe), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
    tap_ctrl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    task automatic close_out();
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic load_ir(input logic [2:0] op);
        ctl.scan(1'b1, {29'h0, op}, `IR_W, dout, oe_ok);
        chk(dout[1:0], 2'b01);
        chk(oe_ok, 1'b1);
    endtask

    // Mode changes cross from the test clock, so let them settle first.
    task automatic pins(input logic [7:0] o, input logic [7:0] e);
        repeat (8) @(negedge sys_clk);
        chk(pin_out, o);
        chk(pin_oe, e);
        chk(tdo_oe, 1'b0);
    endtask

    task automatic t_power_up();
        pins(8'h5a, 8'hff);
        @(negedge sys_clk);
        core_out = 8'ha3;
        core_oe = 1'b0;
        pins(8'ha3, 8'h00);
        @(negedge sys_clk);
        core_out = 8'h5a;
        core_oe = 1'b1;
        pins(8'h5a, 8'hff);
        ctl.scan(1'b0, 32'h0, `ID_W, dout, oe_ok);
        chk(dout, `ID_VALUE);
    endtask

    task automatic t_bypass();
        logic [2:0] ops [4];
        ops = '{3'h7, 3'h3, 3'h5, 3'h6};
        foreach (ops[i]) begin
            load_ir(ops[i]);
            ctl.scan(1'b0, 32'h3, 2, dout, oe_ok);
            chk(dout[1:0], 2'b10);
        end
    endtask

    task automatic t_sample();
        @(negedge sys_clk);
        pin_in = 8'ha5;
        load_ir(`OP_SAMPLE);
        ctl.scan(1'b0, 32'h13c, `BSR_LEN, dout, oe_ok);
        chk(dout[8:0], 9'h1a5);
        pins(8'h5a, 8'hff);
    endtask

    task automatic t_extest();
        load_ir(`OP_EXTEST);
        pins(8'h3c, 8'hff);
        @(negedge sys_clk);
        pin_in = 8'hc3;
        ctl.scan(1'b0, 32'h0f0, `BSR_LEN, dout, oe_ok);
        chk(dout[8:0], 9'h1c3);
        pins(8'hf0, 8'h00);
    endtask

    task automatic t_high_z();
        load_ir(`OP_SAMPLE_Z);
        pins(8'h5a, 8'h00);
        ctl.scan(1'b0, 32'h000, `BSR_LEN, dout, oe_ok);
        chk(dout[8:0], 9'h0c3);
        pins(8'h5a, 8'h00);
    endtask

    // A mode-pin reset must drop high impedance and re-arm the gate cell.
    task automatic t_mode_reset();
        ctl.reset5();
        pins(8'h5a, 8'hff);
        ctl.scan(1'b0, 32'h0, `ID_W, dout, oe_ok);
        chk(dout, `ID_VALUE);
        load_ir(`OP_EXTEST);
        repeat (8) @(negedge sys_clk);
        chk(pin_oe, 8'hff);
    endtask

    initial begin
        rst_b = 1'b0;
        pin_in = 8'h00;
        core_out = 8'h5a;
        core_oe = 1'b1;
        #1;
        repeat (4) ctl.move(1'b1);
        @(negedge sys_clk);
        rst_b = 1'b1;
        ctl.reset5();
        t_power_up();
        t_bypass();
        t_sample();
        t_extest();
        t_high_z();
        t_mode_reset();
        close_out();
    end
endmodule // sram_boundary_scan_tap_test

`default_nettype wire
